/* include/phs_consts.svh */
`ifndef PHS_CONSTS_SVH
`define PHS_CONSTS_SVH

`define PHS_ADDR_W          10
`define PHS_DATA_W          8

`define PHS_OFS_REF_SEL     10'h01c
`define PHS_OFS_HOLD_CTRL   10'h01d
`define PHS_OFS_PLL_STATUS  10'h01f
`define PHS_OFS_IRQ_STATUS  10'h0a0
`define PHS_OFS_IRQ_ENABLE  10'h0a1
`define PHS_OFS_IRQ_CLEAR   10'h0a2

`define PHS_RST_REF_SEL     8'h00
`define PHS_RST_HOLD_CTRL   8'h00
`define PHS_RST_IRQ_ENABLE  3'h0

`define PHS_REF_DIFF_BIT    0
`define PHS_REF_PRIM_PWR    1

`define PHS_HC_HOLD_EN_A    0
`define PHS_HC_EXT_HOLD     1
`define PHS_HC_HOLD_EN_B    2
`define PHS_HC_LD_COMP_EN   3
`define PHS_HC_STAT_DIS     4

`define PHS_ST_DLD          0
`define PHS_ST_PRIM_FREQ    1
`define PHS_ST_SEC_FREQ     2
`define PHS_ST_VCO_FREQ     3
`define PHS_ST_SEC_SEL      4
`define PHS_ST_HOLD_ACT     5
`define PHS_ST_CAL_DONE     6

`define PHS_IRQ_W           3
`define PHS_IRQ_CAL_DONE    0
`define PHS_IRQ_HOLD_ENTER  1
`define PHS_IRQ_LOCK_LOST   2

`endif

/* include/phs_pkg.sv */
`include "phs_consts.svh"

package phs_pkg;

    typedef struct packed {
        logic                   wrStb;
        logic                   rdStb;
        logic [`PHS_ADDR_W-1:0] addr;
        logic [`PHS_DATA_W-1:0] wrData;
    } phs_bus_s;

    typedef struct packed {
        logic calDone;
        logic pllLocked;
        logic ldCompOut;
        logic syncHold;
        logic primaryOk;
        logic secondaryOk;
        logic primaryFreqAbove;
        logic secondaryFreqAbove;
        logic vcoFreqAbove;
    } phs_sense_s;

    typedef enum logic [1:0] {
        PHS_TRACK   = 2'b00,
        PHS_HOLD    = 2'b01,
        PHS_RECOVER = 2'b11
    } phs_hold_e;

endpackage : phs_pkg

/* rtl/phs_regs.sv */
// Contract
// - Reference-select bit 0 picks reference mode: 0 single-ended, 1 differential.
// - Automatic primary/secondary switchover acts only in single-ended mode.
// - Reference-select bit 1 powers the primary reference input on.
// - Holdover control bit 4 set suppresses status register readback.
// - Holdover control bit 3 enables the lock-detect pin comparator.
// - Comparator disabled: automatic holdover sees the lock-detect pin high.
// - Comparator enabled: its result tells whether the PLL was locked.
// - Holdover works only when control bits 2 and 0 are both set.
// - Control bit 1: 0 automatic circuit, 1 sync pin controls holdover.
// - External control takes the automatic controller out of holdover.
// - Status bit 6 reads 1 once VCO calibration has finished.
// - Status bit 5 reads 1 while actually in holdover.
// - Status bit 4 reads 1 when the secondary reference feeds the PLL.
// - Status bit 3 reads 1 when VCO frequency exceeds its threshold.
// - Status bit 2 reads 1 when secondary frequency exceeds its threshold.
// - Status bit 0 reports digital lock detect.
`timescale 1ns/100ps
`default_nettype none
`include "phs_consts.svh"

module phs_regs (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire logic                   ce,
    input  wire phs_pkg::phs_bus_s      bus,
    input  wire phs_pkg::phs_sense_s    sense,
    output logic [`PHS_DATA_W-1:0]      rdData_q,
    output logic                        irq_q,
    output logic                        diffRefMode,
    output logic                        primaryPowerOn,
    output logic                        ldCompEnable,
    output logic                        useSecondary_q,
    output logic                        holdActive_q
);

    logic [`PHS_DATA_W-1:0] refSel_q;
    logic [`PHS_DATA_W-1:0] holdCtrl_q;
    logic [`PHS_IRQ_W-1:0]  irqStat_q;
    logic [`PHS_IRQ_W-1:0]  irqEn_q;
    logic [`PHS_IRQ_W-1:0]  irqEvt;
    logic [`PHS_DATA_W-1:0] statusWord;
    logic [`PHS_DATA_W-1:0] rdData_d;
    logic                   calDone_q;
    logic                   locked_q;
    logic                   holdEnabled;
    logic                   extHold;
    logic                   ldTrue;
    logic                   selRefOk;
    logic                   useSecondary_d;
    logic                   holdActive_d;
    phs_pkg::phs_hold_e     holdState_q;
    phs_pkg::phs_hold_e     holdState_d;

    function automatic logic hit(input logic [`PHS_ADDR_W-1:0] a,
                                 input logic [`PHS_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign diffRefMode    = refSel_q[`PHS_REF_DIFF_BIT];
    assign primaryPowerOn = refSel_q[`PHS_REF_PRIM_PWR];
    assign ldCompEnable   = holdCtrl_q[`PHS_HC_LD_COMP_EN];
    assign holdEnabled    = holdCtrl_q[`PHS_HC_HOLD_EN_B]
                          & holdCtrl_q[`PHS_HC_HOLD_EN_A];
    assign extHold        = holdCtrl_q[`PHS_HC_EXT_HOLD];
    assign ldTrue         = ldCompEnable ? sense.ldCompOut : 1'b1;
    assign selRefOk       = useSecondary_q ? sense.secondaryOk
                                           : sense.primaryOk;

    // Configuration registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            refSel_q   <= `PHS_RST_REF_SEL;
            holdCtrl_q <= `PHS_RST_HOLD_CTRL;
            irqEn_q    <= `PHS_RST_IRQ_ENABLE;
        end else if (ce && bus.wrStb) begin
            if (hit(bus.addr, `PHS_OFS_REF_SEL)) begin
                refSel_q <= bus.wrData;
            end
            if (hit(bus.addr, `PHS_OFS_HOLD_CTRL)) begin
                holdCtrl_q <= bus.wrData;
            end
            if (hit(bus.addr, `PHS_OFS_IRQ_ENABLE)) begin
                irqEn_q <= bus.wrData[`PHS_IRQ_W-1:0];
            end
        end
    end

    // Revertive switchover: fall back to secondary only while primary is bad
    always_comb begin
        useSecondary_d = useSecondary_q;
        if (diffRefMode) begin
            useSecondary_d = 1'b0;
        end else if (sense.primaryOk) begin
            useSecondary_d = 1'b0;
        end else if (sense.secondaryOk) begin
            useSecondary_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            useSecondary_q <= 1'b0;
        end else if (ce) begin
            useSecondary_q <= useSecondary_d;
        end
    end

    // Automatic holdover controller
    always_comb begin
        holdState_d = holdState_q;
        if (!holdEnabled || extHold) begin
            holdState_d = phs_pkg::PHS_TRACK;
        end else begin
            unique case (holdState_q)
                phs_pkg::PHS_TRACK: begin
                    if (!selRefOk && ldTrue) begin
                        holdState_d = phs_pkg::PHS_HOLD;
                    end
                end
                phs_pkg::PHS_HOLD: begin
                    if (selRefOk) begin
                        holdState_d = phs_pkg::PHS_RECOVER;
                    end
                end
                phs_pkg::PHS_RECOVER: begin
                    if (!selRefOk) begin
                        holdState_d = phs_pkg::PHS_HOLD;
                    end else if (sense.pllLocked) begin
                        holdState_d = phs_pkg::PHS_TRACK;
                    end
                end
                default: begin
                    holdState_d = phs_pkg::PHS_TRACK;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            holdState_q <= phs_pkg::PHS_TRACK;
        end else if (ce) begin
            holdState_q <= holdState_d;
        end
    end

    // Automatic holdover is active in HOLD only (sync pin rules under external control); RECOVER already tracks the reference
    always_comb begin
        if (!holdEnabled) begin
            holdActive_d = 1'b0;
        end else if (extHold) begin
            holdActive_d = sense.syncHold;
        end else begin
            holdActive_d = (holdState_d == phs_pkg::PHS_HOLD);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            holdActive_q <= 1'b0;
        end else if (ce) begin
            holdActive_q <= holdActive_d;
        end
    end

    // Event history for edge detection
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            calDone_q <= 1'b0;
            locked_q  <= 1'b0;
        end else if (ce) begin
            calDone_q <= sense.calDone;
            locked_q  <= sense.pllLocked;
        end
    end

    always_comb begin
        irqEvt                      = '0;
        irqEvt[`PHS_IRQ_CAL_DONE]   = sense.calDone & ~calDone_q;
        irqEvt[`PHS_IRQ_HOLD_ENTER] = holdActive_d & ~holdActive_q;
        irqEvt[`PHS_IRQ_LOCK_LOST]  = locked_q & ~sense.pllLocked;
    end

    // Sticky status: a new event wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `PHS_IRQ_W; gi = gi + 1) begin : gIrq
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    irqStat_q[gi] <= 1'b0;
                end else if (ce) begin
                    if (irqEvt[gi]) begin
                        irqStat_q[gi] <= 1'b1;
                    end else if (bus.wrStb && bus.wrData[gi]
                                 && hit(bus.addr, `PHS_OFS_IRQ_CLEAR)) begin
                        irqStat_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(irqStat_q & irqEn_q);
        end
    end

    // Status word is pure readback of live state, nothing stores it
    always_comb begin
        statusWord                    = '0;
        statusWord[`PHS_ST_DLD]       = sense.pllLocked;
        statusWord[`PHS_ST_PRIM_FREQ] = sense.primaryFreqAbove;
        statusWord[`PHS_ST_SEC_FREQ]  = sense.secondaryFreqAbove;
        statusWord[`PHS_ST_VCO_FREQ]  = sense.vcoFreqAbove;
        statusWord[`PHS_ST_SEC_SEL]   = useSecondary_q;
        statusWord[`PHS_ST_HOLD_ACT]  = holdActive_q;
        statusWord[`PHS_ST_CAL_DONE]  = sense.calDone;
    end

    always_comb begin
        rdData_d = '0;
        if (bus.rdStb) begin
            unique case (bus.addr)
                `PHS_OFS_REF_SEL:    rdData_d = refSel_q;
                `PHS_OFS_HOLD_CTRL:  rdData_d = holdCtrl_q;
                `PHS_OFS_PLL_STATUS: begin
                    if (!holdCtrl_q[`PHS_HC_STAT_DIS]) begin
                        rdData_d = statusWord;
                    end
                end
                `PHS_OFS_IRQ_STATUS: rdData_d = {5'h00, irqStat_q};
                `PHS_OFS_IRQ_ENABLE: rdData_d = {5'h00, irqEn_q};
                default:             rdData_d = '0;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_q <= '0;
        end else if (ce) begin
            rdData_q <= rdData_d;
        end
    end

    sequence refSelWr;
        ce && bus.wrStb && hit(bus.addr, `PHS_OFS_REF_SEL);
    endsequence

    sequence statusRd;
        ce && bus.rdStb && hit(bus.addr, `PHS_OFS_PLL_STATUS);
    endsequence

    sequence holdRefBack;
        ce && holdEnabled && !extHold
           && holdState_q == phs_pkg::PHS_HOLD && selRefOk;
    endsequence

    ref_sel_wr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        refSelWr |=> diffRefMode == $past(bus.wrData[0])
                     && primaryPowerOn == $past(bus.wrData[1]))
        else $error("reference select write not applied");

    diff_no_switch_a: assert property (@(posedge core_clk)
        disable iff (!arst_n) (ce && diffRefMode) |=> !useSecondary_q)
        else $error("switchover acted in differential mode");

    stat_suppress_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (statusRd and holdCtrl_q[`PHS_HC_STAT_DIS]) |=> rdData_q == 8'h00)
        else $error("status readback not suppressed");

    stat_read_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (statusRd and !holdCtrl_q[`PHS_HC_STAT_DIS])
            |=> rdData_q == $past(statusWord) && !$past(bus.wrStb))
        else $error("status readback wrong");

    hold_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ce && !holdEnabled)
            |=> !holdActive_q && holdState_q == phs_pkg::PHS_TRACK)
        else $error("holdover active while disabled");

    ext_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ce && holdEnabled && extHold)
            |=> holdActive_q == $past(sense.syncHold)
                && holdState_q == phs_pkg::PHS_TRACK)
        else $error("sync pin holdover not followed");

    ld_true_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ce && holdEnabled && !extHold && !ldCompEnable && !selRefOk
            && holdState_q == phs_pkg::PHS_TRACK)
            |=> holdState_q == phs_pkg::PHS_HOLD && holdActive_q)
        else $error("automatic holdover missed with comparator off");

    ld_comp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ce && ldCompEnable && !sense.ldCompOut
            && holdState_q == phs_pkg::PHS_TRACK)
            |=> holdState_q == phs_pkg::PHS_TRACK)
        else $error("holdover entered without prior lock");

    hold_recover_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        holdRefBack |=> holdState_q == phs_pkg::PHS_RECOVER && !holdActive_q)
        else $error("holdover did not leave on reference return");

    irq_level_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce |=> irq_q == $past(|(irqStat_q & irqEn_q)))
        else $error("interrupt level wrong");

    sequence recoverLost;
        ce && holdEnabled && !extHold
           && holdState_q == phs_pkg::PHS_RECOVER && !selRefOk;
    endsequence

    sequence primaryFails;
        ce && !diffRefMode && !sense.primaryOk && sense.secondaryOk;
    endsequence

    sequence statusWr;
        ce && bus.wrStb && hit(bus.addr, `PHS_OFS_PLL_STATUS);
    endsequence

    hold_reenter_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        recoverLost |=> holdState_q == phs_pkg::PHS_HOLD && holdActive_q)
        else $error("holdover not re-entered on reference loss");

    sec_select_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        primaryFails |=> useSecondary_q)
        else $error("secondary reference not selected");

    prim_revert_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (ce && sense.primaryOk) |=> !useSecondary_q)
        else $error("primary reference not restored");

    status_ro_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        statusWr |=> $stable(refSel_q) && $stable(holdCtrl_q)
                     && $stable(irqEn_q))
        else $error("status register write changed state");

    irq_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ce && irqEvt[`PHS_IRQ_LOCK_LOST])
            |=> irqStat_q[`PHS_IRQ_LOCK_LOST])
        else $error("interrupt event lost");

endmodule : phs_regs
`default_nettype wire

/* tb/phs_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "phs_consts.svh"

module phs_regs_tb;
    logic                   core_clk;
    logic                   arst_n;
    logic                   ce;
    phs_pkg::phs_bus_s      bus;
    phs_pkg::phs_sense_s    sense;
    phs_pkg::phs_sense_s    sv;
    logic [`PHS_DATA_W-1:0] rdData_q;
    logic [`PHS_DATA_W-1:0] rdv;
    logic                   irq_q;
    logic                   diffRefMode;
    logic                   primaryPowerOn;
    logic                   ldCompEnable;
    logic                   useSecondary_q;
    logic                   holdActive_q;
    int                     miscompares;
    int                     checksDone;
    int                     stPos [5] = '{`PHS_ST_CAL_DONE, `PHS_ST_VCO_FREQ,
                                          `PHS_ST_SEC_FREQ, `PHS_ST_PRIM_FREQ,
                                          `PHS_ST_DLD};

    phs_regs dut (
        .core_clk       (core_clk),
        .arst_n         (arst_n),
        .ce             (ce),
        .bus            (bus),
        .sense          (sense),
        .rdData_q       (rdData_q),
        .irq_q          (irq_q),
        .diffRefMode    (diffRefMode),
        .primaryPowerOn (primaryPowerOn),
        .ldCompEnable   (ldCompEnable),
        .useSecondary_q (useSecondary_q),
        .holdActive_q   (holdActive_q)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic stopTest;
        if (miscompares == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stopTest

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wrReg(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus.wrStb  <= 1'b1;
        bus.addr   <= a;
        bus.wrData <= d;
        @(posedge core_clk);
        bus.wrStb  <= 1'b0;
        #1;
    endtask : wrReg

    task automatic rdReg(input logic [9:0] a);
        @(posedge core_clk);
        bus.rdStb <= 1'b1;
        bus.addr  <= a;
        @(posedge core_clk);
        bus.rdStb <= 1'b0;
        #1;
        rdv = rdData_q;
    endtask : rdReg

    task automatic senseSet;
        @(posedge core_clk);
        sense <= sv;
        #1;
    endtask : senseSet

    // Registered outputs settle within a few cycles; bound the wait
    task automatic waitBit(input string what, input bit hold, input logic e);
        for (int i = 0; i < 8; i++) begin
            if ((hold ? holdActive_q : useSecondary_q) === e) break;
            tick(1);
        end
        check(what, {7'h00, hold ? holdActive_q : useSecondary_q}, {7'h00, e});
    endtask : waitBit

    initial begin
        #500000;
        miscompares++;
        stopTest();
    end

    initial begin
        arst_n = 1'b0;
        ce     = 1'b1;
        bus    = '0;
        sv     = '0;
        sv.primaryOk   = 1'b1;
        sv.secondaryOk = 1'b1;
        sense  = sv;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        tick(1);
        check("outputs", {4'h0, irq_q, diffRefMode, primaryPowerOn,
              ldCompEnable}, 8'h00);
        rdReg(`PHS_OFS_REF_SEL);
        check("refsel reset", rdv, `PHS_RST_REF_SEL);
        rdReg(`PHS_OFS_HOLD_CTRL);
        check("holdctrl reset", rdv, `PHS_RST_HOLD_CTRL);
        wrReg(`PHS_OFS_REF_SEL, 8'h03);
        check("refsel out", {6'h00, diffRefMode, primaryPowerOn},
              8'h03);
        wrReg(`PHS_OFS_REF_SEL, 8'hfc);
        rdReg(`PHS_OFS_REF_SEL);
        check("refsel back", rdv, 8'hfc);
        check("refsel off", {6'h00, diffRefMode, primaryPowerOn},
              8'h00);
        wrReg(`PHS_OFS_REF_SEL, 8'h00);
        for (int i = 0; i < 5; i++) begin
            sv.calDone          = (i == 0);
            sv.vcoFreqAbove     = (i == 1);
            sv.secondaryFreqAbove = (i == 2);
            sv.primaryFreqAbove = (i == 3);
            sv.pllLocked        = (i == 4);
            senseSet();
            rdReg(`PHS_OFS_PLL_STATUS);
            check("status flag", rdv, 8'h01 << stPos[i]);
        end
        wrReg(`PHS_OFS_PLL_STATUS, 8'hff);
        rdReg(`PHS_OFS_PLL_STATUS);
        check("status written", rdv, 8'h01);
        wrReg(`PHS_OFS_HOLD_CTRL, 8'h10);
        rdReg(`PHS_OFS_PLL_STATUS);
        check("status off", rdv, 8'h00);
        rdReg(`PHS_OFS_HOLD_CTRL);
        check("holdctrl back", rdv, 8'h10);
        sv.primaryOk   = 1'b0;
        sv.secondaryOk = 1'b0;
        sv.pllLocked   = 1'b0;
        senseSet();
        wrReg(`PHS_OFS_HOLD_CTRL, 8'h01);
        tick(4);
        check("hold half a", {7'h00, holdActive_q}, 8'h00);
        wrReg(`PHS_OFS_HOLD_CTRL, 8'h04);
        tick(4);
        check("hold half b", {7'h00, holdActive_q}, 8'h00);
        wrReg(`PHS_OFS_HOLD_CTRL, 8'h05);
        waitBit("hold auto", 1'b1, 1'b1);
        rdReg(`PHS_OFS_PLL_STATUS);
        check("status hold", {7'h00, rdv[`PHS_ST_HOLD_ACT]}, 8'h01);
        sv.primaryOk = 1'b1;
        senseSet();
        waitBit("hold recover", 1'b1, 1'b0);
        sv.primaryOk = 1'b0;
        senseSet();
        waitBit("hold again", 1'b1, 1'b1);
        sv.primaryOk = 1'b1;
        senseSet();
        waitBit("hold left", 1'b1, 1'b0);
        sv.pllLocked = 1'b1;
        senseSet();
        wrReg(`PHS_OFS_HOLD_CTRL, 8'h0d);
        check("comp enable", {7'h00, ldCompEnable}, 8'h01);
        sv.primaryOk = 1'b0;
        senseSet();
        tick(4);
        check("comp low", {7'h00, holdActive_q}, 8'h00);
        sv.ldCompOut = 1'b1;
        senseSet();
        waitBit("comp high", 1'b1, 1'b1);
        sv.primaryOk = 1'b1;
        senseSet();
        tick(4);
        wrReg(`PHS_OFS_HOLD_CTRL, 8'h07);
        sv.primaryOk = 1'b0;
        senseSet();
        tick(4);
        check("ext idle", {7'h00, holdActive_q}, 8'h00);
        sv.syncHold = 1'b1;
        senseSet();
        tick(1);
        check("ext hold", {7'h00, holdActive_q}, 8'h01);
        sv.syncHold = 1'b0;
        senseSet();
        tick(1);
        check("ext free", {7'h00, holdActive_q}, 8'h00);
        wrReg(`PHS_OFS_HOLD_CTRL, 8'h00);
        sv.secondaryOk = 1'b1;
        senseSet();
        waitBit("switch sec", 1'b0, 1'b1);
        rdReg(`PHS_OFS_PLL_STATUS);
        check("status sec", {7'h00, rdv[`PHS_ST_SEC_SEL]}, 8'h01);
        wrReg(`PHS_OFS_REF_SEL, 8'h01);
        waitBit("switch diff", 1'b0, 1'b0);
        rdReg(`PHS_OFS_PLL_STATUS);
        check("status diff", {7'h00, rdv[`PHS_ST_SEC_SEL]}, 8'h00);
        wrReg(`PHS_OFS_REF_SEL, 8'h00);
        sv.primaryOk = 1'b1;
        sv.calDone   = 1'b0;
        senseSet();
        tick(4);
        wrReg(`PHS_OFS_IRQ_ENABLE, 8'h00);
        wrReg(`PHS_OFS_IRQ_CLEAR, 8'h07);
        rdReg(`PHS_OFS_IRQ_STATUS);
        check("irq cleared", rdv, 8'h00);
        sv.calDone   = 1'b1;
        sv.pllLocked = 1'b0;
        senseSet();
        tick(2);
        rdReg(`PHS_OFS_IRQ_STATUS);
        check("irq events", rdv, 8'h05);
        check("irq masked", {7'h00, irq_q}, 8'h00);
        wrReg(`PHS_OFS_IRQ_ENABLE, 8'h01);
        tick(2);
        check("irq raised", {7'h00, irq_q}, 8'h01);
        rdReg(`PHS_OFS_IRQ_ENABLE);
        check("irq enable", rdv, 8'h01);
        wrReg(`PHS_OFS_IRQ_CLEAR, 8'h01);
        tick(2);
        check("irq dropped", {7'h00, irq_q}, 8'h00);
        rdReg(`PHS_OFS_IRQ_STATUS);
        check("irq left", rdv, 8'h04);
        rdReg(`PHS_OFS_IRQ_CLEAR);
        check("clear reads", rdv, 8'h00);
        rdReg(10'h3ff);
        check("unmapped", rdv, 8'h00);
        @(posedge core_clk);
        ce <= 1'b0;
        wrReg(`PHS_OFS_REF_SEL, 8'haa);
        @(posedge core_clk);
        ce <= 1'b1;
        rdReg(`PHS_OFS_REF_SEL);
        check("ce frozen", rdv, 8'h00);
        stopTest();
    end
endmodule : phs_regs_tb

`default_nettype wire
